// ==== shared/ecf_defs.svh ====
// ecf_defs.svh: offsets, widths, reset values and counts
// assumes inclusion by the package and the design top only
`ifndef ECF_DEFS_SVH
`define ECF_DEFS_SVH
`define ECF_AW          8
`define ECF_CTRL_ADDR   8'h00
`define ECF_STAT_ADDR   8'h04
`define ECF_CTRL_W      15
`define ECF_CTRL_RST    15'h0041
`define ECF_RESP_OKAY   2'h0
`define ECF_RESP_SLVERR 2'h2
`define ECF_MODE_FIFO   3'h2
`define ECF_MODE_ECP    3'h3
`define ECF_MODE_TEST   3'h6
`define ECF_IO_DATA     11'h400
`define ECF_IO_ADDR     11'h000
`define ECF_DEPTH       5'h10
`define ECF_THR_CAP     5'h0F
`define ECF_BURST_MAX   6'h20
`define ECF_LDRQ_BITS   3'h4
`endif

// ==== shared/ecf_pkg.sv ====
// ecf_pkg: types shared by the service control block
// assumes ecf_defs.svh sits beside it on the include path
`include "ecf_defs.svh"
package ecf_pkg;
   typedef struct packed {
      logic [2:0] dma_chan;
      logic [3:0] thr;
      logic       ack_irq_enable;
      logic       fault_irq_enable_n;
      logic [2:0] mode;
      logic       dir;
      logic       dma_request_enable;
      logic       service_irq_mask;
   } ecf_ctrl_t;

   typedef enum logic [1:0] {
      LQ_IDLE = 2'b01,
      LQ_SEND = 2'b10
   } ecf_lq_t;

   typedef struct packed {
      logic        io_stb;
      logic        io_write;
      logic [10:0] io_addr;
      logic        dma_stb;
      logic        dma_tc;
   } ecf_host_t;

   typedef struct packed {
      ecf_ctrl_t   ctrl;
      logic [4:0]  cnt;
      logic [1:0]  flt_s;
      logic [1:0]  ack_s;
      logic        flt_d;
      logic        ack_d;
      logic        evt;
      logic        irq;
      logic [5:0]  burst;
      logic        hold;
      ecf_lq_t     lst;
      logic [3:0]  lsh;
      logic [2:0]  lbit;
      logic        sent_act;
      logic        ldrq_n;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ecf_state_t;
endpackage

// ==== tb/ecf_dma_host_model.sv ====
// ecf_dma_host_model: host dma controller listening on the request line
// assumes frames of start, three channel bits and an active bit
`timescale 1ns/1ps
module ecf_dma_host_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ldrq_n,
   input  wire logic       run,
   input  wire logic [7:0] count,
   output logic            dma_stb,
   output logic            dma_tc
);
   logic [2:0] ph;
   logic [3:0] gap;
   logic [7:0] left;
   logic       act;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph <= 3'h0;
         gap <= 4'h0;
         left <= 8'h00;
         act <= 1'b0;
         dma_stb <= 1'b0;
         dma_tc <= 1'b0;
      end else begin
         if (ph == 3'h0)
            ph <= {2'h0, !ldrq_n};
         else if (ph == 3'h4) begin
            act <= ldrq_n;
            ph <= 3'h0;
         end else
            ph <= ph + 3'h1;
         gap <= gap + 4'h1;
         dma_stb <= 1'b0;
         dma_tc <= 1'b0;
         // count is loaded while the controller is off
         if (!run)
            left <= count;
         else if (act && left != 8'h00 && gap == 4'hF) begin
            dma_stb <= 1'b1;
            dma_tc <= (left == 8'h01);
            left <= left - 8'h01;
         end
      end
   end
endmodule

// ==== tb/tb_ecf_top.sv ====
// tb_ecf_top: self-checking bench of the fifo service request block
// assumes ecf_pkg compiled first and the host dma model beside it
`timescale 1ns/1ps
module tb_ecf_top;
   import ecf_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, rv;
   logic        io_stb = 1'b0, io_wr = 1'b0, push = 1'b0, pop = 1'b0;
   logic        flt_n = 1'b1, ack_n = 1'b1, run = 1'b0;
   logic [10:0] io_addr = 11'h000;
   logic [7:0]  dcount = 8'h00;
   logic        dma_stb, dma_tc, ldrq_n, irq;
   logic [4:0]  fcnt;
   logic [3:0]  fl [2] = '{4'hB, 4'hF};
   int          error_cnt = 0;
   int          samples_checked = 0;
   ecf_host_t   host;
   assign host = {io_stb, io_wr, io_addr, dma_stb, dma_tc};
   always #5 clk = ~clk;

   ecf_top ecf_top_inst (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .HOST(host), .PERIPH_PUSH(push), .PERIPH_POP(pop),
      .PERIPHERAL_FAULT_N(flt_n), .PERIPHERAL_ACK_N(ack_n), .LDRQ_N(ldrq_n),
      .SERVICE_IRQ(irq), .FIFO_COUNT(fcnt));

   ecf_dma_host_model ecf_dma_host_model_inst (.clk(clk), .rst_n(rst_n),
      .ldrq_n(ldrq_n), .run(run), .count(dcount), .dma_stb(dma_stb), .dma_tc(dma_tc));

   function automatic logic [31:0] cw(logic [3:0] f, logic [2:0] m, logic a, logic fn,
                                      logic d, logic e, logic k);
      return {20'h0, f, a, fn, m, d, e, k};
   endfunction

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      rs = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
   endtask

   task automatic hio(input logic w, input logic [10:0] a);
      @(posedge clk);
      io_stb <= 1'b1;
      io_wr <= w;
      io_addr <= a;
      @(posedge clk);
      io_stb <= 1'b0;
   endtask

   task automatic pulse(input logic p, input int n);
      repeat (n) begin
         @(posedge clk);
         if (p) push <= 1'b1;
         else pop <= 1'b1;
         @(posedge clk);
         push <= 1'b0;
         pop <= 1'b0;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      idle(20000);
      error_cnt++;
      final_report;
   end

   initial begin
      idle(10);
      rst_n <= 1'b1;
      rd(8'h00);
      chk("ctrl", rv, 32'h41);
      rd(8'h08);
      chk("rresp", 32'(rs), 32'h2);
      wr(8'h08, 32'h0);
      chk("bresp", 32'(rs), 32'h2);
      chk("count", 32'(fcnt), 32'h0);
      $display("test reset done");
      // forward pio, threshold field 3 gives a write level of 12 free
      wr(8'h00, cw(4'h3, 3'h3, 0, 1, 0, 0, 1));
      idle(4);
      chk("irq", 32'(irq), 32'h0);
      repeat (5) hio(1'b1, 11'h400);
      hio(1'b1, 11'h000);
      hio(1'b0, 11'h000);
      idle(4);
      chk("count", 32'(fcnt), 32'h6);
      wr(8'h00, cw(4'h3, 3'h3, 0, 1, 0, 0, 0));
      idle(4);
      chk("irq", 32'(irq), 32'h0);
      pulse(1'b0, 2);
      idle(4);
      chk("irq", 32'(irq), 32'h1);
      wr(8'h00, 32'h41);
      $display("test forward pio done");
      // reverse pio, field 15 must act as field 14
      foreach (fl[i]) begin
         wr(8'h00, cw(fl[i], 3'h3, 0, 1, 1, 0, 1));
         pulse(1'b1, (fl[i] == 4'hF) ? 1 : 15 - int'(fl[i]));
         idle(4);
         chk("irq", 32'(irq), 32'h0);
         wr(8'h00, cw(fl[i], 3'h3, 0, 1, 1, 0, 0));
         idle(4);
         chk("irq", 32'(irq), 32'h1);
         hio(1'b0, 11'h400);
         idle(4);
         chk("irq", 32'(irq), 32'h0);
         wr(8'h00, 32'h41);
      end
      $display("test reverse pio done");
      dcount <= 8'h02;
      wr(8'h00, cw(4'h0, 3'h3, 0, 1, 1, 1, 1));
      pulse(1'b1, 3);
      idle(10);
      chk("act", 32'(ecf_dma_host_model_inst.act), 32'h0);
      run <= 1'b1;
      wr(8'h00, cw(4'h0, 3'h3, 0, 1, 1, 1, 0));
      idle(80);
      chk("count", 32'(fcnt), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      rd(8'h00);
      chk("mask", 32'(rv[0]), 32'h1);
      rd(8'h04);
      idle(20);
      chk("irq", 32'(irq), 32'h0);
      chk("act", 32'(ecf_dma_host_model_inst.act), 32'h0);
      run <= 1'b0;
      dcount <= 8'h01;
      wr(8'h00, cw(4'h0, 3'h3, 0, 1, 1, 1, 1));
      run <= 1'b1;
      wr(8'h00, cw(4'h0, 3'h3, 0, 1, 1, 1, 0));
      idle(60);
      chk("count", 32'(fcnt), 32'h0);
      run <= 1'b0;
      wr(8'h00, 32'h41);
      rd(8'h04);
      $display("test reverse dma done");
      // test mode moves both ways, compat mode has no address fifo
      wr(8'h00, cw(4'h0, 3'h6, 0, 1, 1, 0, 1));
      repeat (3) hio(1'b1, 11'h400);
      hio(1'b0, 11'h400);
      idle(2);
      chk("count", 32'(fcnt), 32'h2);
      wr(8'h00, 32'h41);
      wr(8'h00, cw(4'h0, 3'h2, 0, 1, 0, 0, 1));
      hio(1'b1, 11'h400);
      hio(1'b1, 11'h000);
      idle(2);
      chk("count", 32'(fcnt), 32'h1);
      // forward dma fills the compat fifo up to terminal count
      dcount <= 8'h03;
      wr(8'h00, cw(4'h0, 3'h2, 0, 1, 0, 1, 1));
      run <= 1'b1;
      wr(8'h00, cw(4'h0, 3'h2, 0, 1, 0, 1, 0));
      idle(80);
      chk("count", 32'(fcnt), 32'h4);
      chk("irq", 32'(irq), 32'h1);
      run <= 1'b0;
      wr(8'h00, 32'h41);
      rd(8'h04);
      $display("test fifo modes done");
      wr(8'h00, cw(4'h0, 3'h0, 1, 1, 0, 0, 1));
      flt_n <= 1'b0;
      idle(8);
      chk("irq", 32'(irq), 32'h0);
      wr(8'h00, cw(4'h0, 3'h0, 1, 0, 0, 0, 1));
      idle(8);
      chk("irq", 32'(irq), 32'h1);
      rd(8'h04);
      flt_n <= 1'b1;
      idle(8);
      flt_n <= 1'b0;
      idle(8);
      chk("irq", 32'(irq), 32'h1);
      rd(8'h04);
      ack_n <= 1'b0;
      idle(8);
      chk("irq", 32'(irq), 32'h0);
      ack_n <= 1'b1;
      idle(8);
      chk("irq", 32'(irq), 32'h1);
      $display("test fault and ack done");
      final_report;
   end
endmodule

// ==== verilog/ecf_top.sv ====
// ecf_top: FIFO service requests (interrupt and DMA) of the ECP port
// assumes LPC cycle decode and the line handshake engine on REF_CLK;
// fault and ack pins are asynchronous and synchronised here
//
// Functional notes
// RULE_01 - mask bit at 1 blocks every DMA request and FIFO service interrupt
// RULE_02 - clearing the mask while a condition holds interrupts at once
// RULE_03 - mask 0 and DMA enable 1: terminal count raises an interrupt
// RULE_04 - forward PIO: interrupt while free bytes reach the write level
// RULE_05 - reverse PIO: interrupt while stored bytes reach the read level
// RULE_06 - fault falling edge, or enable going low during fault, interrupts
// RULE_07 - ack rising edge interrupts when the ack enable is set
// RULE_08 - FIFO disabled after reset, live only in FIFO, ECP or test mode
// RULE_09 - effective threshold is the programmed field plus one
// RULE_10 - effective threshold 16 behaves as 15
// RULE_11 - read level is 16 minus threshold, interrupt held while reached
// RULE_12 - terminal count interrupts and sets the mask, halting DMA
// RULE_13 - DMA request never held beyond 32 consecutive DMA cycles
// RULE_14 - request over encoded request pin, DMA cycle needs no address
// RULE_15 - DMA moves only data, test or compat FIFO per direction and mode
// RULE_16 - reverse DMA requests while data present, stops on empty or TC
// RULE_17 - after empty restart on one byte, after TC also await unmask
// RULE_18 - host sets mode, programs its DMA, then enables and unmasks
// RULE_19 - host stops: DMA off, mask, disable, drain; restart reversed
// RULE_20 - only a terminal count ends a DMA transfer properly
// RULE_21 - PIO data and test FIFO at 400H, write-only address FIFO at 000H
// RULE_22 - write level is 16 minus threshold, counted in free bytes
// RULE_23 - occupancy 0 to 16 tracked and compared every clock
`timescale 1ns/1ps
`include "ecf_defs.svh"
module ecf_top (
   input  wire logic               REF_CLK,
   input  wire logic               RST_N,
   input  wire logic [`ECF_AW-1:0] S_AXI_AWADDR,
   input  wire logic               S_AXI_AWVALID,
   output logic                    S_AXI_AWREADY,
   input  wire logic [31:0]        S_AXI_WDATA,
   input  wire logic [3:0]         S_AXI_WSTRB,
   input  wire logic               S_AXI_WVALID,
   output logic                    S_AXI_WREADY,
   output logic [1:0]              S_AXI_BRESP,
   output logic                    S_AXI_BVALID,
   input  wire logic               S_AXI_BREADY,
   input  wire logic [`ECF_AW-1:0] S_AXI_ARADDR,
   input  wire logic               S_AXI_ARVALID,
   output logic                    S_AXI_ARREADY,
   output logic [31:0]             S_AXI_RDATA,
   output logic [1:0]              S_AXI_RRESP,
   output logic                    S_AXI_RVALID,
   input  wire logic               S_AXI_RREADY,
   input  ecf_pkg::ecf_host_t      HOST,
   input  wire logic               PERIPH_PUSH,
   input  wire logic               PERIPH_POP,
   input  wire logic               PERIPHERAL_FAULT_N,
   input  wire logic               PERIPHERAL_ACK_N,
   output logic                    LDRQ_N,
   output logic                    SERVICE_IRQ,
   output logic [4:0]              FIFO_COUNT
);
   import ecf_pkg::*;

   ecf_state_t r_reg;
   ecf_state_t r_next;

   logic       fifo_en;
   logic [4:0] eff_thr;
   logic [4:0] svc_level;
   logic [4:0] free_cnt;
   logic       pio_lvl;
   logic       dma_want;
   logic       fwd;
   logic       io_data_hit;
   logic       io_addr_hit;
   logic       push_host;
   logic       pop_host;
   logic       push;
   logic       pop;
   logic       tc_evt;
   logic       flt_evt;
   logic       ack_evt;
   logic       wr_go;
   logic       rd_go;
   logic       stat_rd;
   logic       ctrl_wr;
   ecf_ctrl_t  wr_ctrl;

   // fifo alive only in the FIFO-using modes
   assign fifo_en = (r_reg.ctrl.mode == `ECF_MODE_FIFO) || // RULE_08
                    (r_reg.ctrl.mode == `ECF_MODE_ECP)  ||
                    (r_reg.ctrl.mode == `ECF_MODE_TEST);
   assign fwd     = ~r_reg.ctrl.dir;

   // 16 folds onto 15 so the level never reaches zero
   assign eff_thr   = {1'b0, r_reg.ctrl.thr} + 5'h01; // RULE_09
   assign svc_level = (eff_thr > `ECF_THR_CAP) ? // RULE_10
                      (`ECF_DEPTH - `ECF_THR_CAP) :
                      (`ECF_DEPTH - eff_thr); // RULE_11 RULE_22
   assign free_cnt  = `ECF_DEPTH - r_reg.cnt;

   assign pio_lvl = fifo_en && !r_reg.ctrl.service_irq_mask && // RULE_01 RULE_02
                    !r_reg.ctrl.dma_request_enable &&
                    (fwd ? (free_cnt >= svc_level) : // RULE_04 RULE_23
                           (r_reg.cnt >= svc_level)); // RULE_05 RULE_11

   assign dma_want = fifo_en && r_reg.ctrl.dma_request_enable &&
                     !r_reg.ctrl.service_irq_mask && !r_reg.hold && // RULE_01 RULE_17
                     (fwd ? (r_reg.cnt != `ECF_DEPTH) :
                            (r_reg.cnt != 5'h00)); // RULE_16

   // address FIFO exists only forward in ECP mode and cannot be read
   assign io_data_hit = HOST.io_stb && (HOST.io_addr == `ECF_IO_DATA); // RULE_21
   assign io_addr_hit = HOST.io_stb && HOST.io_write && fwd &&
                        (HOST.io_addr == `ECF_IO_ADDR) &&
                        (r_reg.ctrl.mode == `ECF_MODE_ECP); // RULE_21

   // dma cycles are taken by channel alone, the address is ignored
   assign push_host = fifo_en && ((io_data_hit && HOST.io_write &&
                      (fwd || r_reg.ctrl.mode == `ECF_MODE_TEST)) ||
                      io_addr_hit ||
                      (HOST.dma_stb && fwd)); // RULE_14 RULE_15
   assign pop_host  = fifo_en && ((io_data_hit && !HOST.io_write &&
                      (!fwd || r_reg.ctrl.mode == `ECF_MODE_TEST)) ||
                      (HOST.dma_stb && !fwd)); // RULE_15
   assign push = (push_host || (PERIPH_PUSH && !fwd)) &&
                 (r_reg.cnt != `ECF_DEPTH);
   assign pop  = (pop_host || (PERIPH_POP && fwd)) &&
                 (r_reg.cnt != 5'h00);

   assign tc_evt  = fifo_en && HOST.dma_stb && HOST.dma_tc &&
                    r_reg.ctrl.dma_request_enable; // RULE_20
   assign flt_evt = (!r_reg.ctrl.fault_irq_enable_n &&
                     r_reg.flt_d && !r_reg.flt_s[1]) || // RULE_06
                    (ctrl_wr && !wr_ctrl.fault_irq_enable_n &&
                     r_reg.ctrl.fault_irq_enable_n && !r_reg.flt_s[1]);
   assign ack_evt = r_reg.ctrl.ack_irq_enable &&
                    !r_reg.ack_d && r_reg.ack_s[1]; // RULE_07

   assign wr_go   = S_AXI_AWVALID && S_AXI_WVALID && !r_reg.bvalid;
   // enable change seen on the write path, not r_next, so no logic loop
   assign ctrl_wr = wr_go && (S_AXI_AWADDR == `ECF_CTRL_ADDR);
   assign rd_go   = S_AXI_ARVALID && !r_reg.rvalid;
   assign stat_rd = rd_go && (S_AXI_ARADDR == `ECF_STAT_ADDR);

   always_comb begin
      wr_ctrl = r_reg.ctrl;
      if (S_AXI_WSTRB[0]) begin
         wr_ctrl[7:0] = S_AXI_WDATA[7:0];
      end
      if (S_AXI_WSTRB[1]) begin
         wr_ctrl[`ECF_CTRL_W-1:8] = S_AXI_WDATA[`ECF_CTRL_W-1:8];
      end
   end

   always_comb begin
      r_next = r_reg;

      // register bus
      if (wr_go) begin
         r_next.bvalid = 1'b1;
         if (S_AXI_AWADDR == `ECF_CTRL_ADDR) begin
            r_next.ctrl  = wr_ctrl;
            r_next.bresp = `ECF_RESP_OKAY;
         end else begin
            r_next.bresp = `ECF_RESP_SLVERR;
         end
      end else if (r_reg.bvalid && S_AXI_BREADY) begin
         r_next.bvalid = 1'b0;
      end

      if (rd_go) begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = `ECF_RESP_OKAY;
         if (S_AXI_ARADDR == `ECF_CTRL_ADDR) begin
            r_next.rdata = {17'h00000, r_reg.ctrl};
         end else if (stat_rd) begin
            r_next.rdata = {23'h000000, r_reg.hold, r_reg.evt,
                            r_reg.sent_act, r_reg.irq, r_reg.cnt};
         end else begin
            r_next.rdata = 32'h00000000;
            r_next.rresp = `ECF_RESP_SLVERR;
         end
      end else if (r_reg.rvalid && S_AXI_RREADY) begin
         r_next.rvalid = 1'b0;
      end

      // terminal count wins over a same-cycle unmask write
      if (tc_evt) begin
         r_next.ctrl.service_irq_mask = 1'b1; // RULE_12
      end

      // occupancy
      if (!fifo_en) begin
         r_next.cnt = 5'h00; // RULE_08
      end else if (push && !pop) begin
         r_next.cnt = r_reg.cnt + 5'h01; // RULE_23
      end else if (pop && !push) begin
         r_next.cnt = r_reg.cnt - 5'h01;
      end

      // pin synchronisers and edge history
      r_next.flt_s = {r_reg.flt_s[0], PERIPHERAL_FAULT_N};
      r_next.ack_s = {r_reg.ack_s[0], PERIPHERAL_ACK_N};
      r_next.flt_d = r_reg.flt_s[1];
      r_next.ack_d = r_reg.ack_s[1];

      // sticky events, cleared by a status read; a new event wins
      if (stat_rd) begin
         r_next.evt = 1'b0;
      end
      if ((tc_evt && !r_reg.ctrl.service_irq_mask) || // RULE_03
          flt_evt || ack_evt) begin
         r_next.evt = 1'b1;
      end
      r_next.irq = pio_lvl || r_next.evt; // RULE_02

      // consecutive dma cycles under one request
      if (!r_reg.sent_act) begin
         r_next.burst = 6'h00;
      end else if (HOST.dma_stb && fifo_en) begin
         r_next.burst = r_reg.burst + 6'h01;
         if (r_reg.burst + 6'h01 >= `ECF_BURST_MAX) begin
            r_next.hold = 1'b1; // RULE_13
         end
      end
      // the pause lasts until the deassert frame has gone out
      if (r_reg.hold && !r_reg.sent_act && r_reg.lst == LQ_IDLE) begin
         r_next.hold = 1'b0;
      end

      // serial request frame: start, channel lsb first, active bit, one high gap
      case (r_reg.lst)
         LQ_IDLE: begin
            r_next.ldrq_n = 1'b1;
            if (dma_want != r_reg.sent_act) begin
               r_next.lst      = LQ_SEND;
               r_next.ldrq_n   = 1'b0; // RULE_14
               r_next.lsh      = {dma_want, r_reg.ctrl.dma_chan};
               r_next.lbit     = 3'h0;
               r_next.sent_act = dma_want; // RULE_16 RULE_17
            end
         end
         LQ_SEND: begin
            r_next.ldrq_n = r_reg.lsh[0];
            r_next.lsh    = {1'b1, r_reg.lsh[3:1]};
            r_next.lbit   = r_reg.lbit + 3'h1;
            if (r_reg.lbit == `ECF_LDRQ_BITS) begin
               r_next.lst = LQ_IDLE;
            end
         end
         default: begin
            r_next.lst = LQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         r_reg          <= '0;
         r_reg.ctrl     <= `ECF_CTRL_RST;
         r_reg.flt_s    <= 2'h3;
         r_reg.ack_s    <= 2'h3;
         r_reg.flt_d    <= 1'b1;
         r_reg.ack_d    <= 1'b1;
         r_reg.lst      <= LQ_IDLE;
         r_reg.lsh      <= 4'hF;
         r_reg.ldrq_n   <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY  = wr_go;
   assign S_AXI_BVALID  = r_reg.bvalid;
   assign S_AXI_BRESP   = r_reg.bresp;
   assign S_AXI_ARREADY = !r_reg.rvalid;
   assign S_AXI_RVALID  = r_reg.rvalid;
   assign S_AXI_RDATA   = r_reg.rdata;
   assign S_AXI_RRESP   = r_reg.rresp;
   assign LDRQ_N        = r_reg.ldrq_n;
   assign SERVICE_IRQ   = r_reg.irq;
   assign FIFO_COUNT    = r_reg.cnt;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_frame_start;
      r_reg.lst == LQ_IDLE && dma_want != r_reg.sent_act;
   endsequence
   sequence s_frame_body;
      !LDRQ_N ##5 LDRQ_N;
   endsequence

   chk_mask_no_dma: assert property ( // RULE_01
      r_reg.ctrl.service_irq_mask |-> !dma_want)
      else $error("dma wanted while masked");

   chk_unmask_irq: assert property ( // RULE_02
      $fell(r_reg.ctrl.service_irq_mask) && pio_lvl |=> SERVICE_IRQ)
      else $error("no interrupt on unmask");

   chk_pio_level: assert property ( // RULE_04
      pio_lvl |=> SERVICE_IRQ)
      else $error("pio level without interrupt");

   chk_tc_irq_mask: assert property ( // RULE_03
      tc_evt && !r_reg.ctrl.service_irq_mask
      |=> r_reg.ctrl.service_irq_mask && SERVICE_IRQ [*1])
      else $error("tc did not interrupt and mask");

   chk_fault_edge: assert property ( // RULE_06
      !r_reg.ctrl.fault_irq_enable_n && $fell(r_reg.flt_s[1]) |=> r_reg.evt)
      else $error("fault edge lost");

   chk_ack_edge: assert property ( // RULE_07
      r_reg.ctrl.ack_irq_enable && $rose(r_reg.ack_s[1]) |=> SERVICE_IRQ)
      else $error("ack edge lost");

   chk_level_cap: assert property ( // RULE_10
      r_reg.ctrl.thr == 4'hF |-> svc_level == 5'h01)
      else $error("threshold 16 not folded");

   chk_level_calc: assert property ( // RULE_09
      r_reg.ctrl.thr != 4'hF |-> svc_level == 5'h0F - {1'b0, r_reg.ctrl.thr})
      else $error("service level wrong");

   chk_burst_cap: assert property ( // RULE_13
      r_reg.burst <= `ECF_BURST_MAX)
      else $error("dma burst too long");

   chk_fifo_off: assert property ( // RULE_08
      !fifo_en |=> r_reg.cnt == 5'h00)
      else $error("count kept while disabled");

   chk_ldrq_frame: assert property ( // RULE_14
      s_frame_start |=> s_frame_body)
      else $error("request frame malformed");

   chk_rev_empty: assert property ( // RULE_16
      r_reg.sent_act && r_reg.ctrl.dir && r_reg.cnt == 5'h00 && !pop && !push
      && r_reg.lst == LQ_IDLE |=> !r_reg.sent_act)
      else $error("reverse dma still requested on empty");

   sequence s_fault_unmask;
      ctrl_wr && !wr_ctrl.fault_irq_enable_n && r_reg.ctrl.fault_irq_enable_n &&
      !r_reg.flt_s[1];
   endsequence

   chk_fault_enable: assert property ( // RULE_06
      s_fault_unmask |=> r_reg.evt && SERVICE_IRQ)
      else $error("fault enable during fault lost");

   chk_fwd_level: assert property ( // RULE_04 RULE_22
      fifo_en && !r_reg.ctrl.service_irq_mask && !r_reg.ctrl.dma_request_enable &&
      !r_reg.ctrl.dir && (`ECF_DEPTH - r_reg.cnt) >= svc_level |=> SERVICE_IRQ)
      else $error("forward free level without interrupt");

   chk_rev_level: assert property ( // RULE_05 RULE_11
      fifo_en && !r_reg.ctrl.service_irq_mask && !r_reg.ctrl.dma_request_enable &&
      r_reg.ctrl.dir && r_reg.cnt >= svc_level |=> SERVICE_IRQ)
      else $error("reverse fill level without interrupt");

   chk_mask_quiet: assert property ( // RULE_01
      r_reg.ctrl.service_irq_mask && !r_next.evt |=> !SERVICE_IRQ)
      else $error("service interrupt while masked");

   chk_tc_stop: assert property ( // RULE_12
      tc_evt |=> !dma_want)
      else $error("dma still wanted after terminal count");

   chk_rev_want: assert property ( // RULE_16 RULE_17
      fifo_en && r_reg.ctrl.dma_request_enable && !r_reg.ctrl.service_irq_mask &&
      r_reg.ctrl.dir && !r_reg.hold && r_reg.cnt != 5'h00 |-> dma_want)
      else $error("reverse dma not wanted with data");

   chk_count_range: assert property ( // RULE_23
      r_reg.cnt <= `ECF_DEPTH)
      else $error("occupancy beyond depth");

   chk_addr_read: assert property ( // RULE_21
      fifo_en && HOST.io_stb && !HOST.io_write && HOST.io_addr == `ECF_IO_ADDR &&
      !HOST.dma_stb && !PERIPH_PUSH && !PERIPH_POP |=> r_reg.cnt == $past(r_reg.cnt))
      else $error("address fifo read moved the count");
endmodule
